// File: design/eop_link_if.sv
// Pin-level link between the transceiver end and the MAC end
`timescale 1ns/1ps
`default_nettype none
interface eop_link_if;
  logic       ref_pin_o;    // Reference clock out of the transceiver
  logic       ref_pin_oe;   // High while the transceiver drives it
  logic       sync;         // Shared sync / transmit sync from MAC
  logic       rx_sync_o;    // Receive sync from transceiver
  logic       rx_sync_oe;   // High while the transceiver drives it
  logic [7:0] txd0;
  logic [7:0] txd1;
  logic [7:0] tx_en;        // Bit 4 is the transmit clock in source-sync mode
  logic [7:0] rxd0;
  logic [7:0] rxd1;
  logic [7:0] crs_dv;       // Bit 4 is the receive clock in source-sync mode

  modport phy (output ref_pin_o, ref_pin_oe, rx_sync_o, rx_sync_oe, rxd0, rxd1, crs_dv,
               input sync, txd0, txd1, tx_en);
  modport mac (input ref_pin_o, ref_pin_oe, rx_sync_o, rx_sync_oe, rxd0, rxd1, crs_dv,
               output sync, txd0, txd1, tx_en);
endinterface
`default_nettype wire

// File: design/eop_mac_end.sv
// MAC end: sync generation, transmit segments and receive capture on the reference clock
`timescale 1ns/1ps
`default_nettype none
module eop_mac_end
  import eop_pkg::*;
(
  input  wire logic            clock,    // Reference clock, also the link clock
  input  wire logic            reset_n,  // Asynchronous reset, active low
  eop_link_if.mac              link,     // Pins toward the transceiver
  input  wire logic [1:0]      mode,     // Must match the transceiver strap
  input  wire logic [7:0]      port_10m, // Port runs at 10 Mb/s
  input  wire eop_pkg::eop_bundle_t tx_word, // Segments to send
  output logic                 tx_take,  // Pulse: tx_word taken this edge; 10 Mb/s ports in serial modes take it every tenth pulse
  output eop_pkg::eop_bundle_t rx_word,  // Last received segments
  output logic                 rx_valid  // One-cycle pulse with rx_word
);
  logic [3:0]      pos_q, pos_d, ridx_q, ridx_d, last;
  logic            rmii, ss, start, rstart, rcap, sync_q, rsd_q, rx_valid_d;
  logic [7:0][9:0] rsh_q, rsh_d;
  eop_bundle_t     rx_word_d;
  logic [7:0][1:0] tbits;
  logic [7:0]      tdv;

  assign rmii    = mode[1];
  assign ss      = mode == MODE_SS;
  assign last    = rmii ? RMII_LAST : SEG_LAST;
  assign tx_take = start;

  // ****************************************************************
  // Segment timing and receive capture
  // ****************************************************************
  // Receive bit 0 lags the shared sync by one clock in SMII mode
  always_comb
  begin
    start      = pos_q == last;
    pos_d      = start ? 4'h0 : 4'(pos_q + 4'h1);
    // At or past the last di-bit, so the count leaves its serial reset value
    rstart     = rmii ? (ridx_q >= RMII_LAST) : (ss ? link.rx_sync_o : rsd_q);
    ridx_d     = rstart ? 4'h0 : ((ridx_q == SEG_LAST) ? ridx_q : 4'(ridx_q + 4'h1));
    rcap       = rmii ? (ridx_q == RMII_CAP) : (ridx_q == SEG_CAP);
    rx_valid_d = rcap;
    rx_word_d  = rx_word;
    for (int p = 0; p < NPORT; p++)
    begin
      rsh_d[p] = eop_sh_next(rmii, {link.rxd1[p], link.rxd0[p]}, rsh_q[p]);
      if (rcap)
        rx_word_d[p] = eop_word(rmii, {link.rxd1[p], link.rxd0[p]}, link.crs_dv[p], rsh_q[p]);
    end
  end

  // Registers
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pos_q    <= SEG_LAST;
      ridx_q   <= SEG_LAST;
      sync_q   <= 1'b0;
      rsd_q    <= 1'b0;
      rsh_q    <= '0;
      rx_word  <= '0;
      rx_valid <= 1'b0;
    end
    else
    begin
      pos_q    <= pos_d;
      ridx_q   <= ridx_d;
      sync_q   <= start && !rmii;
      rsd_q    <= sync_q && !ss;
      rsh_q    <= rsh_d;
      rx_word  <= rx_word_d;
      rx_valid <= rx_valid_d;
    end
  end

  // ****************************************************************
  // Transmit lanes
  // ****************************************************************
  for (genvar p = 0; p < NPORT; p++)
  begin : g_tx
    eop_seg_ser u_ser (
      .clock   (clock),
      .reset_n (reset_n),
      .start   (start),
      .rmii    (rmii),
      .rep10   (port_10m[p] && !rmii),
      .word    (tx_word[p]),
      .bits    (tbits[p]),
      .dv      (tdv[p])
    );
    assign link.txd0[p] = tbits[p][0];
    assign link.txd1[p] = tbits[p][1];
  end

  // Port 4 enable pin carries the transmit clock in source-sync mode
  assign link.tx_en = ss ? {3'h0, clock, 4'h0} : (rmii ? tdv : 8'h00);
  assign link.sync  = sync_q;
endmodule // eop_mac_end
`default_nettype wire

// File: design/eop_phy_end.sv
// Transceiver end: mode strap, reference clock out, serial and reduced data lanes
`timescale 1ns/1ps
`default_nettype none
module eop_phy_end
  import eop_pkg::*;
(
  input  wire logic           clock,          // Core clock, 250 MHz
  input  wire logic           reset_n,        // Asynchronous reset, active low
  input  wire logic           link_clk,       // Reference clock from the link
  eop_link_if.phy             link,           // Pins toward the MAC
  input  wire logic           crystal_active, // 25 MHz crystal running
  input  wire logic [1:0]     mode_strap,     // Mode strap pins
  input  wire eop_pkg::eop_bundle_t rx_word,  // Receive segments per port
  input  wire logic           rx_load,        // Offer rx_word
  output logic                rx_ready,       // rx_word may be offered
  input  wire logic [7:0]     medium_busy,    // Medium not idle, per port
  input  wire logic [7:0]     port_10m,       // Port runs at 10 Mb/s
  output eop_pkg::eop_bundle_t tx_word,       // Last transmit segments seen
  output logic                tx_valid,       // One-cycle pulse with tx_word
  output logic [1:0]          link_mode       // Mode taken from the strap
);
  // ****************************************************************
  // Core domain: receive hand-off, transmit pick-up, reference out
  // ****************************************************************
  logic        busy_q, busy_d, req_t_q, req_t_d, ack_s1_q, ack_s2_q;
  eop_bundle_t hold_q, hold_d, tx_word_d, txb_q;
  logic        txt_s1_q, txt_s2_q, txt_s3_q, tx_valid_d;
  logic [2:0]  div_q, div_d;
  logic        xtal_s1_q, xtal_s2_q, ref_q, ref_d;
  logic        req_s3_q, txt_q;

  assign rx_ready = !busy_q;

  // Bundle is held steady until the link side echoes the toggle
  always_comb
  begin
    busy_d     = busy_q && (ack_s2_q != req_t_q);
    req_t_d    = req_t_q;
    hold_d     = hold_q;
    if (rx_load && !busy_q)
    begin
      hold_d  = rx_word;
      req_t_d = !req_t_q;
      busy_d  = 1'b1;
    end
    tx_valid_d = txt_s2_q != txt_s3_q;
    tx_word_d  = tx_valid_d ? txb_q : tx_word;
    div_d      = (div_q == REF_DIV_LAST) ? 3'h0 : 3'(div_q + 3'h1);
    ref_d      = div_d < REF_HIGH;
  end

  // Core registers
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_q    <= 1'b0;
      req_t_q   <= 1'b0;
      hold_q    <= '0;
      ack_s1_q  <= 1'b0;
      ack_s2_q  <= 1'b0;
      txt_s1_q  <= 1'b0;
      txt_s2_q  <= 1'b0;
      txt_s3_q  <= 1'b0;
      tx_word   <= '0;
      tx_valid  <= 1'b0;
      div_q     <= 3'h0;
      ref_q     <= 1'b0;
      xtal_s1_q <= 1'b0;
      xtal_s2_q <= 1'b0;
    end
    else
    begin
      busy_q    <= busy_d;
      req_t_q   <= req_t_d;
      hold_q    <= hold_d;
      ack_s1_q  <= req_s3_q;
      ack_s2_q  <= ack_s1_q;
      txt_s1_q  <= txt_q;
      txt_s2_q  <= txt_s1_q;
      txt_s3_q  <= txt_s2_q;
      tx_word   <= tx_word_d;
      tx_valid  <= tx_valid_d;
      div_q     <= div_d;
      ref_q     <= ref_d;
      xtal_s1_q <= crystal_active;
      xtal_s2_q <= xtal_s1_q;
    end
  end

  // Reference pin: core clock divided down, driven only with the crystal up
  assign link.ref_pin_o  = ref_q;
  assign link.ref_pin_oe = xtal_s2_q;

  // ****************************************************************
  // Link domain: strap, segment timing, lanes
  // ****************************************************************
  logic         req_s1_q, req_s2_q;
  logic [7:0]   med_s1_q, med_s2_q, p10_s1_q, p10_s2_q;
  logic [1:0]   strap_s1_q, strap_s2_q, mode_q, mode_d, cnt_q, cnt_d;
  eop_link_st_e st_q, st_d;
  eop_bundle_t  cur_q, cur_d, txb_d;
  logic [3:0]   rpos_q, rpos_d, tpos_q, tpos_d, last;
  logic         rmii, ss, rstart, tstart, tcap, rxs_q, rxs_d, txt_d;
  logic [7:0]   crs_q, crs_d;
  logic [7:0][9:0] tsh_q, tsh_d;
  logic [7:0][1:0] rbits;

  assign rmii = mode_q[1];
  assign ss   = mode_q == MODE_SS;
  assign last = rmii ? RMII_LAST : SEG_LAST;
  assign link_mode = mode_q;

  // Segment boundaries and transmit sampling
  // Reduced mode runs free on a 4 di-bit count; byte alignment is not recovered
  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    mode_d = mode_q;
    case (st_q)
      ST_STRAP:
      begin
        cnt_d = 2'(cnt_q + 2'h1);
        if (cnt_q == STRAP_WAIT)
        begin
          mode_d = strap_s2_q;
          st_d   = ST_RUN;
        end
      end
      ST_RUN: st_d = ST_RUN;
      default: st_d = ST_STRAP;
    endcase
    // At or past the last di-bit, so the count leaves its serial reset value
    rstart = rmii ? (rpos_q >= RMII_LAST) : (ss ? rpos_q == last : link.sync);
    tstart = rmii ? (rpos_q >= RMII_LAST) : link.sync;
    rpos_d = rstart ? 4'h0 : ((rpos_q == SEG_LAST) ? rpos_q : 4'(rpos_q + 4'h1));
    tpos_d = tstart ? 4'h0 : ((tpos_q == SEG_LAST) ? tpos_q : 4'(tpos_q + 4'h1));
    tcap   = rmii ? (rpos_q == RMII_CAP) : (tpos_q == SEG_CAP);
    rxs_d  = ss && rstart;
    cur_d  = (req_s2_q != req_s3_q) ? hold_q : cur_q;
    txb_d  = txb_q;
    txt_d  = txt_q;
    if (tcap)
    begin
      txt_d = !txt_q;
    end
    for (int p = 0; p < NPORT; p++)
    begin
      // Transmit enable only qualifies reduced mode; bit 1 ignored in serial modes
      tsh_d[p] = eop_sh_next(rmii, rmii ? {link.txd1[p], link.txd0[p]}
                                        : {1'b0, link.txd0[p]}, tsh_q[p]);
      if (tcap)
        txb_d[p] = eop_word(rmii, {link.txd1[p], link.txd0[p]}, link.tx_en[p], tsh_q[p]);
      crs_d[p] = rmii && med_s2_q[p];
    end
  end

  // Link registers
  always_ff @(posedge link_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      req_s1_q   <= 1'b0;
      req_s2_q   <= 1'b0;
      req_s3_q   <= 1'b0;
      med_s1_q   <= 8'h00;
      med_s2_q   <= 8'h00;
      p10_s1_q   <= 8'h00;
      p10_s2_q   <= 8'h00;
      strap_s1_q <= MODE_RST;
      strap_s2_q <= MODE_RST;
      st_q       <= ST_STRAP;
      cnt_q      <= 2'h0;
      mode_q     <= MODE_RST;
      cur_q      <= '0;
      rpos_q     <= SEG_LAST;
      tpos_q     <= SEG_LAST;
      rxs_q      <= 1'b0;
      txt_q      <= 1'b0;
      txb_q      <= '0;
      tsh_q      <= '0;
      crs_q      <= 8'h00;
    end
    else
    begin
      req_s1_q   <= req_t_q;
      req_s2_q   <= req_s1_q;
      req_s3_q   <= req_s2_q;
      med_s1_q   <= medium_busy;
      med_s2_q   <= med_s1_q;
      p10_s1_q   <= port_10m;
      p10_s2_q   <= p10_s1_q;
      strap_s1_q <= mode_strap;
      strap_s2_q <= strap_s1_q;
      st_q       <= st_d;
      cnt_q      <= cnt_d;
      mode_q     <= mode_d;
      cur_q      <= cur_d;
      rpos_q     <= rpos_d;
      tpos_q     <= tpos_d;
      rxs_q      <= rxs_d;
      txt_q      <= txt_d;
      txb_q      <= txb_d;
      tsh_q      <= tsh_d;
      crs_q      <= crs_d;
    end
  end

  // One serialiser per port keeps the lanes independent
  for (genvar p = 0; p < NPORT; p++)
  begin : g_rx
    eop_seg_ser u_ser (
      .clock   (link_clk),
      .reset_n (reset_n),
      .start   (rstart),
      .rmii    (rmii),
      .rep10   (p10_s2_q[p] && !rmii),
      .word    (cur_q[p]),
      .bits    (rbits[p]),
      .dv      ()
    );
    assign link.rxd0[p] = rbits[p][0];
    assign link.rxd1[p] = rbits[p][1];
  end

  // Port 4 carrier pin forwards the link clock as receive clock in source-sync mode
  assign link.crs_dv     = ss ? {crs_q[7:5], link_clk, crs_q[3:0]} : crs_q;
  assign link.rx_sync_o  = rxs_q;
  assign link.rx_sync_oe = ss;
endmodule // eop_phy_end
`default_nettype wire

// File: design/eop_pkg.sv
// Constants, types and helper functions shared by both ends of the octal MAC port link
package eop_pkg;
  // ****************************************************************
  // Geometry and counts
  // ****************************************************************
  localparam int         NPORT       = 8;
  localparam logic [3:0] SEG_LAST    = 4'h9;   // Last bit of a serial segment
  localparam logic [3:0] SEG_CAP     = 4'h8;   // Index before the last sampled bit
  localparam logic [3:0] RMII_LAST   = 4'h3;   // Last di-bit of a byte
  localparam logic [3:0] RMII_CAP    = 4'h2;
  localparam logic [3:0] REP_LAST    = 4'h9;   // Ten copies at 10 Mb/s
  localparam logic [1:0] STRAP_WAIT  = 2'h2;   // Synchroniser settle edges
  // ****************************************************************
  // Modes and reset values
  // ****************************************************************
  localparam logic [1:0] MODE_SMII   = 2'h0;
  localparam logic [1:0] MODE_SS     = 2'h1;
  localparam logic [1:0] MODE_RST    = 2'h3;   // Reduced mode until the strap is taken
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int         CLOCK_MHZ   = 250;
  localparam int         REF_OUT_MHZ = 50;
  localparam logic [2:0] REF_DIV_LAST = 3'(CLOCK_MHZ / REF_OUT_MHZ - 1);
  localparam logic [2:0] REF_HIGH    = 3'(CLOCK_MHZ / REF_OUT_MHZ / 2);
  localparam int         RESET_HOLD_MS = 10;   // Least low time of reset_n

  typedef logic [NPORT-1:0][9:0] eop_bundle_t;
  typedef enum logic [1:0] {ST_STRAP = 2'b01, ST_RUN = 2'b10} eop_link_st_e;

  // Shift one sample into a receive shift register
  function automatic logic [9:0] eop_sh_next(input logic rmii, input logic [1:0] d,
                                             input logic [9:0] sh);
    return rmii ? {d, sh[9:2]} : {d[0], sh[9:1]};
  endfunction

  // Whole word once the last sample arrives; reduced mode packs {byte, 0, flag}
  function automatic logic [9:0] eop_word(input logic rmii, input logic [1:0] d,
                                          input logic flag, input logic [9:0] sh);
    return rmii ? {d, sh[9:4], 1'b0, flag} : {d[0], sh[9:1]};
  endfunction
endpackage

// File: design/eop_seg_ser.sv
// Segment serialiser: one port's 10-bit segments or reduced-mode di-bits
`timescale 1ns/1ps
`default_nettype none
module eop_seg_ser
  import eop_pkg::*;
(
  input  wire logic       clock,    // Link clock
  input  wire logic       reset_n,  // Asynchronous reset, active low
  input  wire logic       start,    // First bit of a segment goes out next
  input  wire logic       rmii,     // Di-bit mode
  input  wire logic       rep10,    // Port runs at 10 Mb/s
  input  wire logic [9:0] word,     // Segment to send
  output logic      [1:0] bits,     // Line bits, registered
  output logic            dv        // Valid flag of the current word
);
  logic [9:0] word_q, word_d;
  logic [3:0] pos_q, pos_d, rep_q, rep_d, idx;
  logic [1:0] bits_d;

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Position saturates so a missing sync cannot index past the word
  always_comb
  begin
    word_d = word_q;
    rep_d  = rep_q;
    pos_d  = (pos_q == SEG_LAST) ? pos_q : 4'(pos_q + 4'h1);
    if (start)
    begin
      pos_d = 4'h0;
      if (!rep10 || rep_q == REP_LAST)
      begin
        word_d = word;
        rep_d  = 4'h0;
      end
      else
        rep_d = 4'(rep_q + 4'h1);
    end
    idx    = 4'({pos_d[1:0], 1'b0} + 3'h2);
    bits_d = rmii ? word_d[idx +: 2] : {1'b0, word_d[pos_d]};
  end

  // Registers
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      word_q <= 10'h000;
      pos_q  <= SEG_LAST;
      rep_q  <= REP_LAST;
      bits   <= 2'h0;
      dv     <= 1'b0;
    end
    else
    begin
      word_q <= word_d;
      pos_q  <= pos_d;
      rep_q  <= rep_d;
      bits   <= bits_d;
      dv     <= word_d[0];  // Flag sits in bit 0 of a reduced-mode word
    end
  end
endmodule // eop_seg_ser
`default_nettype wire

// File: test/eop_link_chk.sv
// Pin checker for the link between the transceiver end and the MAC end
`timescale 1ns/1ps
`default_nettype none
module eop_link_chk
  import eop_pkg::*;
(
  input wire logic       clock,      // Core clock
  input wire logic       link_clk,   // Link clock
  input wire logic       reset_n,    // Reset, active low
  input wire logic [1:0] link_mode,  // Mode taken from the strap
  input wire logic       ref_pin_o,  // Reference clock out
  input wire logic       ref_pin_oe, // Reference driven
  input wire logic       sync,       // Shared sync from the MAC
  input wire logic       rx_sync_o,  // Receive sync
  input wire logic       rx_sync_oe, // Receive sync driven
  input wire logic [7:0] rxd1,       // Receive bit 1
  input wire logic [7:0] tx_en,      // Transmit enable, bit 4 transmit clock
  input wire logic [7:0] crs_dv      // Carrier and valid
);
  // ************************************************************
  // Link domain
  // ************************************************************
  chk_rxd1_low: assert property (@(posedge link_clk) disable iff (!reset_n)
    !link_mode[1] |-> rxd1 == 8'h00) else $error("rxd1 driven in serial mode");
  // Bit 4 is the receive clock in source-sync mode, so it is left out
  chk_crs_low: assert property (@(posedge link_clk) disable iff (!reset_n)
    !link_mode[1] |-> (crs_dv & 8'hef) == 8'h00) else $error("crs_dv driven in serial mode");
  chk_sync_period: assert property (@(posedge link_clk) disable iff (!reset_n)
    !link_mode[1] && sync |=> (!sync)[*8] ##1 !sync ##1 sync)
    else $error("sync not one in ten");
  chk_rx_sync_period: assert property (@(posedge link_clk) disable iff (!reset_n)
    rx_sync_oe && rx_sync_o |=> (!rx_sync_o)[*8] ##1 !rx_sync_o ##1 rx_sync_o)
    else $error("receive sync not one in ten");
  chk_rx_sync_idle: assert property (@(posedge link_clk) disable iff (!reset_n)
    link_mode == MODE_SMII |-> !rx_sync_oe) else $error("receive sync driven in plain serial");
  // ************************************************************
  // Core domain, then covers on both the link clock and the core clock
  // ************************************************************
  // Sampled on the core clock, whose edges never meet the link edges
  chk_ss_rx_clock: assert property (@(posedge clock) disable iff (!reset_n)
    link_mode == MODE_SS && rx_sync_oe |-> crs_dv[4] == link_clk)
    else $error("receive clock pin does not follow link clock");
  chk_ss_tx_clock: assert property (@(posedge clock) disable iff (!reset_n)
    link_mode == MODE_SS && rx_sync_oe |-> tx_en[4] == link_clk)
    else $error("transmit clock pin does not follow link clock");
  chk_ref_period: assert property (@(posedge clock) disable iff (!reset_n)
    ref_pin_oe && $rose(ref_pin_o) |-> ref_pin_o[*2] ##1 (!ref_pin_o)[*3] ##1 ref_pin_o)
    else $error("reference out not core clock over five");
  chk_strap_once: assert property (@(posedge clock) disable iff (!reset_n)
    $changed(link_mode) |-> $past(link_mode) == MODE_RST) else $error("mode changed twice");
  cov_sync: cover property (@(posedge link_clk) disable iff (!reset_n) !link_mode[1] && sync);
  cov_rx_sync: cover property (@(posedge link_clk) disable iff (!reset_n) rx_sync_o);
  cov_ref: cover property (@(posedge clock) disable iff (!reset_n) $rose(ref_pin_o));
endmodule // eop_link_chk
`default_nettype wire

// File: test/octal_phy_rmii_smii_port_tb.sv
// Bench joining both link ends back to back, random segments per mode
`timescale 1ns/1ps
`default_nettype none
module octal_phy_rmii_smii_port_tb;
  import eop_pkg::*;
  logic        clock          = 1'b0;
  logic        link_clk       = 1'b0;
  logic        reset_n        = 1'b0;
  logic        crystal_active = 1'b1;
  logic [1:0]  mode_strap     = 2'h0;
  logic [1:0]  mac_mode       = 2'h0;
  logic        rx_load        = 1'b0;
  logic [7:0]  medium_busy    = 8'h00;
  logic [7:0]  port_10m       = 8'h00;
  eop_bundle_t phy_rx_word    = '0;
  eop_bundle_t mac_tx_word    = '0;
  eop_bundle_t phy_tx_word;
  eop_bundle_t mac_rx_word;
  logic        rx_ready;
  logic        tx_valid;
  logic        tx_take;
  logic        rx_valid;
  logic [1:0]  link_mode;
  logic [1:0]  modes [5] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2};
  int          n_errors  = 0;
  int          cmp_count = 0;
  int          cycles    = 0;
  eop_link_if link ();

  // Core clock, and a link clock offset so its edges never meet core edges
  always #2 clock = ~clock;
  initial
  begin
    #0.3;
    forever #62.5 link_clk = ~link_clk;
  end

  eop_phy_end eop_phy_end_i (.clock(clock), .reset_n(reset_n), .link_clk(link_clk),
    .link(link.phy), .crystal_active(crystal_active), .mode_strap(mode_strap),
    .rx_word(phy_rx_word), .rx_load(rx_load), .rx_ready(rx_ready),
    .medium_busy(medium_busy), .port_10m(port_10m), .tx_word(phy_tx_word),
    .tx_valid(tx_valid), .link_mode(link_mode));
  eop_mac_end eop_mac_end_i (.clock(link_clk), .reset_n(reset_n), .link(link.mac),
    .mode(mac_mode), .port_10m(port_10m), .tx_word(mac_tx_word), .tx_take(tx_take),
    .rx_word(mac_rx_word), .rx_valid(rx_valid));
  eop_link_chk eop_link_chk_i (.clock(clock), .link_clk(link_clk), .reset_n(reset_n),
    .link_mode(link_mode), .ref_pin_o(link.ref_pin_o), .ref_pin_oe(link.ref_pin_oe),
    .sync(link.sync), .rx_sync_o(link.rx_sync_o), .rx_sync_oe(link.rx_sync_oe),
    .rxd1(link.rxd1), .tx_en(link.tx_en), .crs_dv(link.crs_dv));

  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic check(input logic [79:0] seen, input logic [79:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard, well above the roughly 35000 cycles the run needs
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  // Reduced-mode word: one di-bit repeated, so the unknown byte phase cannot matter
  function automatic logic [9:0] rmii_word(input logic [1:0] d, input logic flag);
    return {{4{d}}, 1'b0, flag};
  endfunction

  function automatic eop_bundle_t rand_bundle(input logic rmii);
    eop_bundle_t w;
    for (int p = 0; p < NPORT; p++)
      w[p] = rmii ? rmii_word(2'($urandom), 1'b1) : 10'($urandom);
    return w;
  endfunction

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Strap and crystal only change under reset, as on a board
  task automatic start_mode(input logic [1:0] m, input logic xtal, input logic [7:0] ten);
    @(posedge clock);
    reset_n <= 1'b0;
    mode_strap <= m;
    mac_mode <= m;
    crystal_active <= xtal;
    port_10m <= ten;
    medium_busy <= 8'h00;
    repeat (3) @(posedge link_clk);
    check(link_mode, MODE_RST);
    @(posedge clock);
    reset_n <= 1'b1;
    repeat (8) @(posedge link_clk);
    if (m[1])
      check(link_mode[1], 1'b1);
    else
      check(link_mode, m);
    check(link.ref_pin_oe, xtal);
  endtask

  task automatic tx_test(input logic rmii);
    eop_bundle_t w;
    w = rand_bundle(rmii);
    @(posedge link_clk);
    mac_tx_word <= w;
    repeat (port_10m != 8'h00 ? 125 : 25) @(posedge link_clk);
    for (int i = 0; i < 400 && tx_valid !== 1'b1; i++)
      @(posedge clock);
    check(phy_tx_word, w);
  endtask

  task automatic rx_test(input logic rmii);
    eop_bundle_t w;
    w = rand_bundle(rmii);
    @(posedge clock);
    for (int i = 0; i < 400 && rx_ready !== 1'b1; i++)
      @(posedge clock);
    phy_rx_word <= w;
    rx_load <= 1'b1;
    medium_busy <= rmii ? 8'hff : 8'($urandom);
    @(posedge clock);
    rx_load <= 1'b0;
    repeat (port_10m != 8'h00 ? 125 : 25) @(posedge link_clk);
    for (int i = 0; i < 20 && rx_valid !== 1'b1; i++)
      @(posedge link_clk);
    check(mac_rx_word, w);
  endtask

  // Carrier pins follow the medium in reduced mode only
  task automatic crs_test();
    logic [7:0] b;
    b = 8'($urandom);
    @(posedge clock);
    medium_busy <= b;
    repeat (4) @(posedge link_clk);
    check(link.crs_dv, b);
  endtask

  initial
  begin
    void'($urandom(32'h1cb1));
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      start_mode(modes[k], k != 1, (k == 2 || k == 3) ? 8'($urandom) | 8'h01 : 8'h00);
      tx_test(modes[k][1]);
      rx_test(modes[k][1]);
      tx_test(modes[k][1]);
      if (modes[k][1])
        crs_test();
      else
        check(link.rxd1, 8'h00);
    end
    give_verdict();
  end
endmodule // octal_phy_rmii_smii_port_tb
`default_nettype wire
